// [src/vefc_pkg.sv]
package vefc_pkg;

   // ------------------------------------------------------------
   // sub-addresses
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_PRODUCT = 7'h00;
   localparam logic [6:0] ADDR_OUTFMT  = 7'h01;
   localparam logic [6:0] ADDR_INFMT   = 7'h02;
   localparam logic [6:0] ADDR_VPROC   = 7'h03;

   // ------------------------------------------------------------
   // reset values and write masks (reserved bits held at zero)
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OUTFMT   = 8'h00;
   localparam logic [7:0] RST_INFMT    = 8'h06;
   localparam logic [7:0] RST_VPROC    = 8'ha0;
   localparam logic [7:0] WMASK_OUTFMT = 8'hf8;
   localparam logic [7:0] WMASK_INFMT  = 8'hf7;
   localparam logic [7:0] WMASK_VPROC  = 8'hff;
   localparam logic [7:0] WMASK_NOFLT  = 8'hfc;
   localparam logic [7:0] RD_RESERVED  = 8'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TSTD_HI  = 7;
   localparam int TSTD_LO  = 5;
   localparam int OFMT_HI  = 4;
   localparam int OFMT_LO  = 3;
   localparam int OFMT_RGB = 4;
   localparam int IFMT_HI  = 7;
   localparam int IFMT_LO  = 5;
   localparam int GAMMA    = 4;
   localparam int OVL_HI   = 2;
   localparam int OVL_LO   = 1;
   localparam int QSIZE    = 0;
   localparam int LUMA_LPF = 7;
   localparam int CLIMIT   = 6;
   localparam int SUBC_MODE = 5;
   localparam int PEDESTAL = 4;
   localparam int PIN_SCART = 3;
   localparam int FIRST_EVEN = 2;
   localparam int FLT_HI   = 1;
   localparam int FLT_LO   = 0;

   // ------------------------------------------------------------
   // field codes
   // ------------------------------------------------------------
   localparam logic [2:0] STD_NTSC      = 3'h0;
   localparam logic [2:0] STD_NTSC_NOSU = 3'h1;
   localparam logic [2:0] IFMT_LIN16    = 3'h3;
   localparam logic [2:0] IFMT_LIN24    = 3'h5;
   localparam logic [2:0] IFMT_BLUE     = 3'h7;
   localparam logic [1:0] FLT_ON        = 2'h3;
   localparam logic [2:0] SUBC_PER_NTSC = 3'h3;
   localparam logic [2:0] SUBC_PER_PAL  = 3'h7;

   // ------------------------------------------------------------
   // serial link
   // ------------------------------------------------------------
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h10;
   localparam logic [3:0] BIT_LAST      = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h2,
      ST_SUB  = 4'h3,
      ST_SACK = 4'h4,
      ST_WR   = 4'h5,
      ST_WACK = 4'h6,
      ST_RD   = 4'h7,
      ST_RACK = 4'h8
   } vefc_state_t;

   typedef enum logic [2:0] {
      SRC_LUMA   = 3'h0,
      SRC_CHROMA = 3'h1,
      SRC_COMP   = 3'h2,
      SRC_RED    = 3'h3,
      SRC_GREEN  = 3'h4,
      SRC_BLUE   = 3'h5
   } vefc_src_t;

endpackage

// [src/vefc_regs.sv]
`timescale 1ns/10ps
// How it works
// - product code fixed, writes ignored
// - three-bit timing standard selects video standard
// - two-bit field selects composite plus Y/C or RGB
// - three-bit input format, 111 gives blue screen
// - gamma bit used only in linear RGB
// - overlay mixing field, resets to disable
// - resolution bit enables 2X upscaling
// - luma lowpass enable, resets set
// - composite lower limit clamp enable
// - subcarrier phase reset every 4/8 fields
// - blanking pedestal on RGB outputs
// - pin assignment bit picks RGB mapping
// - first line select only with flicker filter
// - flicker filter only code 11, variant holds 00
// - default RGB pin mapping
// - SCART-compatible RGB pin mapping
// - reserved bits ignored, read as zero
// - sub-address byte, seven bits, auto-increment
module vefc_regs #(
   parameter logic [7:0] PRODUCT_CODE = 8'h3c, // arbitrary value
   parameter bit         HAS_FLICKER  = 1'b1
) (
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_NRST,
   input  wire logic       I_SW_RST,
   input  wire logic       I_SCL,
   input  wire logic       I_SDA,
   input  wire logic       I_SA,
   input  wire logic       I_FIELD_START,
   output logic            O_SDA_OUT,
   output logic            O_SDA_OE,
   output logic [2:0]      O_TIMING_STD,
   output logic            O_STD_IS_NTSC,
   output logic [1:0]      O_OUT_FORMAT,
   output logic [2:0]      O_IN_FORMAT,
   output logic            O_BLUE_SCREEN,
   output logic            O_GAMMA_APPLY,
   output logic            O_GAMMA_28,
   output logic [1:0]      O_OVERLAY_MODE,
   output logic            O_UPSCALE_2X,
   output logic            O_LUMA_LPF,
   output logic            O_COMP_LIMIT,
   output logic            O_RGB_PEDESTAL,
   output logic            O_SCART_PINS,
   output logic            O_FIRST_LINE_EVEN,
   output logic            O_FLICKER_EN,
   output logic            O_SUBC_PHASE_RESET,
   output logic [2:0]      O_Y_PIN_SRC,
   output logic [2:0]      O_C_PIN_SRC,
   output logic [2:0]      O_CV1_PIN_SRC,
   output logic [2:0]      O_CV2_PIN_SRC
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       sa_s;
   logic       scl_d_r;
   logic       sda_d_r;

   // idle bus is high; a reset must not fake a start or stop
   vefc_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h3)
   ) u_sync (
      .i_clk   (I_SYS_CLK),
      .i_nrst  (I_NRST),
      .i_async ({I_SA, I_SDA, I_SCL}),
      .o_sync  (pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sa_s  = pins_s[2];

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic [6:0] dev_addr;

   assign scl_rise  = scl_s & ~scl_d_r;
   assign scl_fall  = ~scl_s & scl_d_r;
   assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign dev_addr  = {vefc_pkg::SLAVE_ADDR_HI, sa_s};

   // ------------------------------------------------------------
   // serial slave state
   // ------------------------------------------------------------
   vefc_pkg::vefc_state_t state_r;
   vefc_pkg::vefc_state_t state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic [6:0] addr_r;
   logic [6:0] addr_nxt;
   logic       oe_r;
   logic       oe_nxt;
   logic       rw_r;
   logic       rw_nxt;
   logic [7:0] rd_data;
   logic       byte_done;

   assign byte_done = (cnt_r == vefc_pkg::BIT_LAST);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      sh_nxt    = sh_r;
      tx_nxt    = tx_r;
      addr_nxt  = addr_r;
      oe_nxt    = oe_r;
      rw_nxt    = rw_r;
      if (bus_stop) begin
         state_nxt = vefc_pkg::ST_IDLE;
         oe_nxt    = 1'b0;
      end else if (bus_start) begin
         state_nxt = vefc_pkg::ST_ADDR;
         cnt_nxt   = 4'h0;
         oe_nxt    = 1'b0;
      end else if (scl_rise) begin
         case (state_r)
            vefc_pkg::ST_ADDR, vefc_pkg::ST_SUB, vefc_pkg::ST_WR: begin
               sh_nxt  = {sh_r[6:0], sda_s};
               cnt_nxt = cnt_r + 4'h1;
            end
            vefc_pkg::ST_RD: begin
               cnt_nxt = cnt_r + 4'h1;
            end
            vefc_pkg::ST_RACK: begin
               // master nack ends the read burst
               if (sda_s) begin
                  state_nxt = vefc_pkg::ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            vefc_pkg::ST_ADDR: begin
               if (byte_done) begin
                  if (sh_r[7:1] == dev_addr) begin
                     state_nxt = vefc_pkg::ST_AACK;
                     oe_nxt    = 1'b1;
                     rw_nxt    = sh_r[0];
                  end else begin
                     state_nxt = vefc_pkg::ST_IDLE;
                  end
               end
            end
            vefc_pkg::ST_AACK: begin
               cnt_nxt = 4'h0;
               if (rw_r) begin
                  state_nxt = vefc_pkg::ST_RD;
                  tx_nxt    = rd_data;
                  oe_nxt    = ~rd_data[7];
               end else begin
                  state_nxt = vefc_pkg::ST_SUB;
                  oe_nxt    = 1'b0;
               end
            end
            vefc_pkg::ST_SUB: begin
               if (byte_done) begin
                  addr_nxt  = sh_r[6:0];
                  state_nxt = vefc_pkg::ST_SACK;
                  oe_nxt    = 1'b1;
               end
            end
            vefc_pkg::ST_WR: begin
               if (byte_done) begin
                  addr_nxt  = addr_r + 7'h01;
                  state_nxt = vefc_pkg::ST_WACK;
                  oe_nxt    = 1'b1;
               end
            end
            vefc_pkg::ST_SACK, vefc_pkg::ST_WACK: begin
               state_nxt = vefc_pkg::ST_WR;
               cnt_nxt   = 4'h0;
               oe_nxt    = 1'b0;
            end
            vefc_pkg::ST_RD: begin
               if (byte_done) begin
                  addr_nxt  = addr_r + 7'h01;
                  state_nxt = vefc_pkg::ST_RACK;
                  oe_nxt    = 1'b0;
               end else begin
                  tx_nxt = {tx_r[6:0], 1'b0};
                  oe_nxt = ~tx_r[6];
               end
            end
            vefc_pkg::ST_RACK: begin
               state_nxt = vefc_pkg::ST_RD;
               cnt_nxt   = 4'h0;
               tx_nxt    = rd_data;
               oe_nxt    = ~rd_data[7];
            end
            default: begin
            end
         endcase
      end
   end

   // software reset also drops the link, as a hardware reset does
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_r <= vefc_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         tx_r    <= 8'h00;
         addr_r  <= 7'h00;
         oe_r    <= 1'b0;
         rw_r    <= 1'b0;
      end else if (I_SW_RST) begin
         state_r <= vefc_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         tx_r    <= 8'h00;
         addr_r  <= 7'h00;
         oe_r    <= 1'b0;
         rw_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         sh_r    <= sh_nxt;
         tx_r    <= tx_nxt;
         addr_r  <= addr_nxt;
         oe_r    <= oe_nxt;
         rw_r    <= rw_nxt;
      end
   end

   // open drain: only ever pulls low
   assign O_SDA_OUT = 1'b0;
   assign O_SDA_OE  = oe_r;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0] outfmt_r;
   logic [7:0] infmt_r;
   logic [7:0] vproc_r;
   logic       wr_stb;
   logic       sel_pid;
   logic       sel_outfmt;
   logic       sel_infmt;
   logic       sel_vproc;
   logic [7:0] vproc_wmask;

   assign wr_stb     = scl_fall & (state_r == vefc_pkg::ST_WR) & byte_done;
   assign sel_pid    = (addr_r == vefc_pkg::ADDR_PRODUCT);
   assign sel_outfmt = (addr_r == vefc_pkg::ADDR_OUTFMT);
   assign sel_infmt  = (addr_r == vefc_pkg::ADDR_INFMT);
   assign sel_vproc  = (addr_r == vefc_pkg::ADDR_VPROC);
   // variant without the filter can never hold a nonzero code
   assign vproc_wmask = HAS_FLICKER ? vefc_pkg::WMASK_VPROC
                                    : vefc_pkg::WMASK_NOFLT;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         outfmt_r <= vefc_pkg::RST_OUTFMT;
         infmt_r  <= vefc_pkg::RST_INFMT;
         vproc_r  <= vefc_pkg::RST_VPROC;
      end else if (I_SW_RST) begin
         outfmt_r <= vefc_pkg::RST_OUTFMT;
         infmt_r  <= vefc_pkg::RST_INFMT;
         vproc_r  <= vefc_pkg::RST_VPROC;
      end else if (wr_stb) begin
         // product code has no write path
         if (sel_outfmt) begin
            outfmt_r <= sh_r & vefc_pkg::WMASK_OUTFMT;
         end
         if (sel_infmt) begin
            infmt_r <= sh_r & vefc_pkg::WMASK_INFMT;
         end
         if (sel_vproc) begin
            vproc_r <= sh_r & vproc_wmask;
         end
      end
   end

   // unmapped sub-addresses read as zero
   assign rd_data = sel_pid    ? PRODUCT_CODE :
                    sel_outfmt ? outfmt_r :
                    sel_infmt  ? infmt_r :
                    sel_vproc  ? vproc_r :
                    vefc_pkg::RD_RESERVED;

   // ------------------------------------------------------------
   // decode for the datapath
   // ------------------------------------------------------------
   logic [2:0] std_w;
   logic [2:0] ifmt_w;
   logic       is_ntsc;
   logic       lin_rgb;
   logic       rgb_mode;
   logic       scart;
   logic       flt_en;

   assign std_w    = outfmt_r[vefc_pkg::TSTD_HI:vefc_pkg::TSTD_LO];
   assign ifmt_w   = infmt_r[vefc_pkg::IFMT_HI:vefc_pkg::IFMT_LO];
   assign is_ntsc  = (std_w == vefc_pkg::STD_NTSC) |
                     (std_w == vefc_pkg::STD_NTSC_NOSU);
   assign lin_rgb  = (ifmt_w == vefc_pkg::IFMT_LIN16) |
                     (ifmt_w == vefc_pkg::IFMT_LIN24);
   assign rgb_mode = outfmt_r[vefc_pkg::OFMT_RGB];
   assign scart    = vproc_r[vefc_pkg::PIN_SCART];
   assign flt_en   = HAS_FLICKER &
                     (vproc_r[vefc_pkg::FLT_HI:vefc_pkg::FLT_LO] == vefc_pkg::FLT_ON);

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_TIMING_STD      <= 3'h0;
         O_STD_IS_NTSC     <= 1'b1;
         O_OUT_FORMAT      <= 2'h0;
         O_IN_FORMAT       <= 3'h0;
         O_BLUE_SCREEN     <= 1'b0;
         O_GAMMA_APPLY     <= 1'b0;
         O_GAMMA_28        <= 1'b0;
         O_OVERLAY_MODE    <= 2'h3;
         O_UPSCALE_2X      <= 1'b0;
         O_LUMA_LPF        <= 1'b1;
         O_COMP_LIMIT      <= 1'b0;
         O_RGB_PEDESTAL    <= 1'b0;
         O_SCART_PINS      <= 1'b0;
         O_FIRST_LINE_EVEN <= 1'b0;
         O_FLICKER_EN      <= 1'b0;
      end else begin
         O_TIMING_STD      <= std_w;
         O_STD_IS_NTSC     <= is_ntsc;
         O_OUT_FORMAT      <= outfmt_r[vefc_pkg::OFMT_HI:vefc_pkg::OFMT_LO];
         O_IN_FORMAT       <= ifmt_w;
         O_BLUE_SCREEN     <= (ifmt_w == vefc_pkg::IFMT_BLUE);
         O_GAMMA_APPLY     <= lin_rgb;
         O_GAMMA_28        <= lin_rgb & infmt_r[vefc_pkg::GAMMA];
         O_OVERLAY_MODE    <= infmt_r[vefc_pkg::OVL_HI:vefc_pkg::OVL_LO];
         O_UPSCALE_2X      <= infmt_r[vefc_pkg::QSIZE];
         O_LUMA_LPF        <= vproc_r[vefc_pkg::LUMA_LPF];
         O_COMP_LIMIT      <= vproc_r[vefc_pkg::CLIMIT];
         O_RGB_PEDESTAL    <= vproc_r[vefc_pkg::PEDESTAL];
         O_SCART_PINS      <= scart;
         O_FIRST_LINE_EVEN <= flt_en & vproc_r[vefc_pkg::FIRST_EVEN];
         O_FLICKER_EN      <= flt_en;
      end
   end

   // ------------------------------------------------------------
   // output pin routing
   // ------------------------------------------------------------
   vefc_pkg::vefc_src_t y_src;
   vefc_pkg::vefc_src_t c_src;
   vefc_pkg::vefc_src_t cv1_src;
   vefc_pkg::vefc_src_t cv2_src;

   assign y_src   = !rgb_mode ? vefc_pkg::SRC_LUMA :
                    scart     ? vefc_pkg::SRC_COMP  : vefc_pkg::SRC_GREEN;
   assign c_src   = !rgb_mode ? vefc_pkg::SRC_CHROMA :
                    scart     ? vefc_pkg::SRC_RED   : vefc_pkg::SRC_BLUE;
   assign cv1_src = !rgb_mode ? vefc_pkg::SRC_COMP :
                    scart     ? vefc_pkg::SRC_GREEN : vefc_pkg::SRC_COMP;
   assign cv2_src = !rgb_mode ? vefc_pkg::SRC_COMP :
                    scart     ? vefc_pkg::SRC_BLUE  : vefc_pkg::SRC_RED;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_Y_PIN_SRC   <= vefc_pkg::SRC_LUMA;
         O_C_PIN_SRC   <= vefc_pkg::SRC_CHROMA;
         O_CV1_PIN_SRC <= vefc_pkg::SRC_COMP;
         O_CV2_PIN_SRC <= vefc_pkg::SRC_COMP;
      end else begin
         O_Y_PIN_SRC   <= y_src;
         O_C_PIN_SRC   <= c_src;
         O_CV1_PIN_SRC <= cv1_src;
         O_CV2_PIN_SRC <= cv2_src;
      end
   end

   // ------------------------------------------------------------
   // subcarrier-to-horizontal phase reset
   // ------------------------------------------------------------
   logic [2:0] fld_cnt_r;
   logic [2:0] subc_last;
   logic       subc_hit;

   // 4 fields in NTSC, 8 in PAL; count restarts when the mode is off
   assign subc_last = is_ntsc ? vefc_pkg::SUBC_PER_NTSC : vefc_pkg::SUBC_PER_PAL;
   assign subc_hit  = I_FIELD_START & vproc_r[vefc_pkg::SUBC_MODE] &
                      (fld_cnt_r >= subc_last);

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         fld_cnt_r          <= 3'h0;
         O_SUBC_PHASE_RESET <= 1'b0;
      end else begin
         O_SUBC_PHASE_RESET <= subc_hit;
         if (!vproc_r[vefc_pkg::SUBC_MODE] | I_SW_RST) begin
            fld_cnt_r <= 3'h0;
         end else if (subc_hit) begin
            fld_cnt_r <= 3'h0;
         end else if (I_FIELD_START) begin
            fld_cnt_r <= fld_cnt_r + 3'h1;
         end
      end
   end

endmodule // vefc_regs

// [src/vefc_sync.sv]
`timescale 1ns/10ps
module vefc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule // vefc_sync

// [verification/vefc_regs_asserts.sv]
`timescale 1ns/10ps
module vefc_regs_asserts (
   input wire logic       I_SYS_CLK,
   input wire logic       I_NRST,
   input wire logic       I_SW_RST,
   input wire logic       I_FIELD_START,
   input wire logic [2:0] O_TIMING_STD,
   input wire logic       O_STD_IS_NTSC,
   input wire logic [1:0] O_OUT_FORMAT,
   input wire logic [2:0] O_IN_FORMAT,
   input wire logic       O_BLUE_SCREEN,
   input wire logic       O_GAMMA_APPLY,
   input wire logic       O_GAMMA_28,
   input wire logic [1:0] O_OVERLAY_MODE,
   input wire logic       O_LUMA_LPF,
   input wire logic       O_SCART_PINS,
   input wire logic       O_FIRST_LINE_EVEN,
   input wire logic       O_FLICKER_EN,
   input wire logic       O_SUBC_PHASE_RESET,
   input wire logic [2:0] O_Y_PIN_SRC,
   input wire logic [2:0] O_C_PIN_SRC,
   input wire logic [2:0] O_CV1_PIN_SRC,
   input wire logic [2:0] O_CV2_PIN_SRC
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);

   // ------------------------------------------------------------
   // multi-step behaviours
   // ------------------------------------------------------------
   // soft reset restores regs, decode lands one edge later
   sequence s_soft_rst;
      I_SW_RST ##1 !I_SW_RST;
   endsequence
   sequence s_subc_end;
      ##1 !O_SUBC_PHASE_RESET;
   endsequence

   a_std_decode: assert property (O_STD_IS_NTSC == (O_TIMING_STD <= 3'h1))
      else $error("ntsc flag disagrees with standard");
   a_blue_decode: assert property (O_BLUE_SCREEN == (O_IN_FORMAT == 3'h7))
      else $error("blue screen flag disagrees with format");
   a_gamma_gate: assert property (O_GAMMA_28 |-> O_GAMMA_APPLY && O_IN_FORMAT inside {3'h3, 3'h5})
      else $error("gamma applied outside linear rgb");
   a_first_gate: assert property (O_FIRST_LINE_EVEN |-> O_FLICKER_EN)
      else $error("first line select without flicker filter");
   a_yc_pins: assert property (!O_OUT_FORMAT[1] |-> O_Y_PIN_SRC == vefc_pkg::SRC_LUMA
      && O_C_PIN_SRC == vefc_pkg::SRC_CHROMA && O_CV1_PIN_SRC == vefc_pkg::SRC_COMP
      && O_CV2_PIN_SRC == vefc_pkg::SRC_COMP) else $error("y/c pin mapping wrong");
   a_rgb_pins: assert property (O_OUT_FORMAT[1] && !O_SCART_PINS |->
      O_Y_PIN_SRC == vefc_pkg::SRC_GREEN && O_C_PIN_SRC == vefc_pkg::SRC_BLUE
      && O_CV1_PIN_SRC == vefc_pkg::SRC_COMP && O_CV2_PIN_SRC == vefc_pkg::SRC_RED)
      else $error("default rgb pin mapping wrong");
   a_scart_pins: assert property (O_OUT_FORMAT[1] && O_SCART_PINS |->
      O_Y_PIN_SRC == vefc_pkg::SRC_COMP && O_C_PIN_SRC == vefc_pkg::SRC_RED
      && O_CV1_PIN_SRC == vefc_pkg::SRC_GREEN && O_CV2_PIN_SRC == vefc_pkg::SRC_BLUE)
      else $error("scart rgb pin mapping wrong");
   a_subc_pulse: assert property (O_SUBC_PHASE_RESET |->
      $past(I_FIELD_START) ##0 s_subc_end)
      else $error("phase reset pulse not tied to field start");
   a_soft_defaults: assert property (s_soft_rst |-> ##1 (O_OVERLAY_MODE == 2'h3
      && O_LUMA_LPF && O_IN_FORMAT == 3'h0 && O_TIMING_STD == 3'h0))
      else $error("soft reset did not restore defaults");
endmodule // vefc_regs_asserts

bind vefc_regs vefc_regs_asserts u_chk (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
   .I_SW_RST(I_SW_RST), .I_FIELD_START(I_FIELD_START), .O_TIMING_STD(O_TIMING_STD),
   .O_STD_IS_NTSC(O_STD_IS_NTSC), .O_OUT_FORMAT(O_OUT_FORMAT), .O_IN_FORMAT(O_IN_FORMAT),
   .O_BLUE_SCREEN(O_BLUE_SCREEN), .O_GAMMA_APPLY(O_GAMMA_APPLY), .O_GAMMA_28(O_GAMMA_28),
   .O_OVERLAY_MODE(O_OVERLAY_MODE), .O_LUMA_LPF(O_LUMA_LPF), .O_SCART_PINS(O_SCART_PINS),
   .O_FIRST_LINE_EVEN(O_FIRST_LINE_EVEN), .O_FLICKER_EN(O_FLICKER_EN),
   .O_SUBC_PHASE_RESET(O_SUBC_PHASE_RESET), .O_Y_PIN_SRC(O_Y_PIN_SRC),
   .O_C_PIN_SRC(O_C_PIN_SRC), .O_CV1_PIN_SRC(O_CV1_PIN_SRC), .O_CV2_PIN_SRC(O_CV2_PIN_SRC));

// [verification/video_encoder_format_config_regs_test.sv]
`timescale 1ns/10ps
module video_encoder_format_config_regs_test;
   localparam int         Q     = 6;     // third of a sent bit, above sync latency
   localparam logic [7:0] PCODE = 8'h5a; // arbitrary value
   logic       clk, nrst, sw_rst, scl, m_sda, fld, gap, sda_oe, is_ntsc, blue, g28, up2x;
   logic       lpf, clim, ped, scart, fev, flt, subc, sdo;
   logic [2:0] tstd, ifmt, ysrc, csrc, c1src, c2src;
   logic [1:0] ofmt, ovl;
   logic [7:0] q[$];
   int         failures = 0, checks = 0, cyc = 0, subc_cnt = 0;
   wire        sda_line = m_sda & (~sda_oe | sdo); // open drain, pulled up

   vefc_regs #(.PRODUCT_CODE(PCODE)) dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_SW_RST(sw_rst),
      .I_SCL(scl), .I_SDA(sda_line), .I_SA(1'b0), .I_FIELD_START(fld), .O_SDA_OUT(sdo),
      .O_SDA_OE(sda_oe), .O_TIMING_STD(tstd), .O_STD_IS_NTSC(is_ntsc), .O_OUT_FORMAT(ofmt),
      .O_IN_FORMAT(ifmt), .O_BLUE_SCREEN(blue), .O_GAMMA_APPLY(gap), .O_GAMMA_28(g28),
      .O_OVERLAY_MODE(ovl), .O_UPSCALE_2X(up2x), .O_LUMA_LPF(lpf), .O_COMP_LIMIT(clim),
      .O_RGB_PEDESTAL(ped), .O_SCART_PINS(scart), .O_FIRST_LINE_EVEN(fev),
      .O_FLICKER_EN(flt), .O_SUBC_PHASE_RESET(subc), .O_Y_PIN_SRC(ysrc), .O_C_PIN_SRC(csrc),
      .O_CV1_PIN_SRC(c1src), .O_CV2_PIN_SRC(c2src));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (subc === 1'b1) subc_cnt <= subc_cnt + 1;
      if (cyc == 80000) begin
         failures++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // bus helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt;
      repeat (Q) @(negedge clk);
   endtask
   task automatic start;
      m_sda = 1'b1; wt; scl = 1'b1; wt; m_sda = 1'b0; wt; scl = 1'b0; wt;
   endtask
   task automatic stop;
      m_sda = 1'b0; wt; scl = 1'b1; wt; m_sda = 1'b1; wt;
   endtask
   task automatic sendb(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         m_sda = b[i]; wt; scl = 1'b1; wt; scl = 1'b0; wt;
      end
      m_sda = 1'b1; wt; scl = 1'b1; wt; check(!sda_line, 1'b1); scl = 1'b0; wt;
   endtask
   task automatic recvb(output logic [7:0] b, input logic nack);
      m_sda = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         wt; scl = 1'b1; wt; b[i] = sda_line; scl = 1'b0;
      end
      wt; m_sda = nack; wt; scl = 1'b1; wt; scl = 1'b0; wt;
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
      start; sendb(8'h40);
      sendb(sub);
      foreach (d[k]) sendb(d[k]);
      stop;
   endtask
   task automatic rd(input logic [7:0] sub, input int n);
      logic [7:0] b;
      q = {};
      start; sendb(8'h40); sendb(sub); start; sendb(8'h41);
      for (int k = 0; k < n; k++) begin
         recvb(b, k == n - 1);
         q.push_back(b);
      end
      stop;
   endtask
   task automatic rchk(input logic [7:0] sub, input logic [7:0] exp);
      rd(sub, 1);
      check(q[0], exp);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rchk(8'h00, PCODE);
      rchk(8'h01, 8'h00); rchk(8'h02, 8'h06); rchk(8'h03, 8'ha0);
      check(ovl, 2'h3); check(lpf, 1'b1);
   endtask
   task automatic t_reserved;
      wr(8'h00, '{8'hff}); rchk(8'h00, PCODE);
      wr(8'h01, '{8'hff}); rchk(8'h01, 8'hf8);
      wr(8'h02, '{8'hff}); rchk(8'h02, 8'hf7); rchk(8'h04, 8'h00);
   endtask
   task automatic t_burst;
      // sub-address msb dropped: 81 lands on 01
      wr(8'h81, '{8'h48, 8'h2e, 8'h54});
      rd(8'h01, 3);
      check(q[0], 8'h48); check(q[1], 8'h26); check(q[2], 8'h54);
      check(clim, 1'b1); check(ped, 1'b1); check(fev, 1'b0);
   endtask
   task automatic t_std;
      for (int s = 0; s < 8; s++) begin
         logic [1:0] of;
         of = s[0] ? 2'h3 : (s[1] ? 2'h2 : 2'h0);
         wr(8'h01, '{{s[2:0], of, 3'h0}});
         check(tstd, s[2:0]); check(is_ntsc, s < 2); check(ofmt, of);
      end
   endtask
   task automatic t_infmt;
      for (int i = 0; i < 8; i++) begin
         wr(8'h02, '{{i[2:0], 4'hf, i == 0}});
         check(ifmt, i[2:0]); check(blue, i == 7); check(gap, i == 3 || i == 5);
         check(g28, i == 3 || i == 5); check(up2x, i == 0); check(ovl, 2'h3);
      end
   endtask
   task automatic t_vproc;
      wr(8'h01, '{8'h10}); wr(8'h03, '{8'h00}); check(scart, 1'b0);
      check(ysrc, vefc_pkg::SRC_GREEN); check(csrc, vefc_pkg::SRC_BLUE);
      check(c1src, vefc_pkg::SRC_COMP); check(c2src, vefc_pkg::SRC_RED); check(lpf, 1'b0);
      wr(8'h03, '{8'h08}); check(scart, 1'b1);
      check(ysrc, vefc_pkg::SRC_COMP); check(csrc, vefc_pkg::SRC_RED);
      check(c1src, vefc_pkg::SRC_GREEN); check(c2src, vefc_pkg::SRC_BLUE);
      wr(8'h02, '{8'h06}); wr(8'h03, '{8'h87});
      check(flt, 1'b1); check(fev, 1'b1); check(lpf, 1'b1);
      wr(8'h03, '{8'h06}); check(flt, 1'b0); check(fev, 1'b0);
      wr(8'h03, '{8'h05}); check(flt, 1'b0);
   endtask
   task automatic subc_run(input logic [2:0] std, input logic [7:0] vp, input int n,
                           input logic [7:0] exp);
      int base;
      wr(8'h01, '{{std, 5'h0}}); wr(8'h03, '{8'h00}); wr(8'h03, '{vp});
      base = subc_cnt;
      repeat (n) begin
         fld = 1'b1; @(negedge clk); fld = 1'b0; repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      check(8'(subc_cnt - base), exp);
   endtask
   task automatic t_soft;
      wr(8'h01, '{8'hff}); wr(8'h02, '{8'h00}); wr(8'h03, '{8'h00});
      sw_rst = 1'b1; @(negedge clk); sw_rst = 1'b0; repeat (4) @(negedge clk);
      check(ovl, 2'h3); rchk(8'h01, 8'h00); rchk(8'h03, 8'ha0);
   endtask
   task automatic conclude;
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      scl = 1'b1; m_sda = 1'b1; nrst = 1'b0; sw_rst = 1'b0; fld = 1'b0;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
      t_reset; t_reserved; t_burst; t_std; t_infmt; t_vproc;
      subc_run(3'h0, 8'h20, 8, 8'h02); subc_run(3'h2, 8'h20, 15, 8'h01);
      subc_run(3'h0, 8'h00, 8, 8'h00);
      t_soft;
      conclude;
   end
endmodule // video_encoder_format_config_regs_test
